// >>> core/irq_enable_and_external_irq.sv
`timescale 1ns/1ps
`include "irq_consts.svh"

// Behaviour
// - bits 7 and 3 of extended enable read zero, writes ignored.
// - extended enable at address 0xe7 on every page, reset to zero.
// - cap scan end request passes only while enable bit 6 set.
// - cap comparator request passes only while enable bit 5 set.
// - cap conversion done request passes only while enable bit 4 set.
// - rtc alarm request passes only while enable bit 2 set.
// - port match requests pass only while enable bit 1 set.
// - supply warning request passes only while enable bit 0 set.
// - each external input has own polarity and edge/level choice.
// - sense 1 edge, 0 level; polarity 0 low, 1 high.
// - external inputs sample selected port pin regardless of crossbar.
// - external pending flags sit in timer control bits 1 and 3.
// - edge mode sets pending on active edge, clears on vectoring.
// - level mode pending follows the input's active level.
module irq_enable_and_external_irq #(
   parameter int PORT_PINS = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] sfr_addr,
   input wire irq_pkg::sfr_byte_t sfr_wdata,
   input wire logic sfr_we,
   output irq_pkg::sfr_byte_t sfr_rdata,
   output logic sfr_hit,
   input wire logic [PORT_PINS-1:0] port_pins,
   input wire logic cap_scan_end_flag,
   input wire logic cap_compare_flag,
   input wire logic cap_conv_done_flag,
   input wire logic rtc_alarm_flag,
   input wire logic port_match_flag,
   input wire logic supply_warn_flag,
   input wire logic ext_irq_zero_vector_ack,
   input wire logic ext_irq_one_vector_ack,
   output logic cap_scan_end_req,
   output logic cap_compare_req,
   output logic cap_conv_done_req,
   output logic rtc_alarm_req,
   output logic port_match_req,
   output logic supply_warn_req,
   output logic ext_irq_zero_req,
   output logic ext_irq_one_req
);
   import irq_pkg::*;

   typedef struct packed {
      sfr_byte_t extended_interrupt_enable_two;
      sfr_byte_t ext_irq_pin_config;
      logic ext_irq_zero_sense;
      logic ext_irq_one_sense;
      sfr_byte_t rdata;
   } top_state_t;

   top_state_t cur;
   top_state_t next_cur;
   ext_irq_cfg_if zero_if ();
   ext_irq_cfg_if one_if ();
   logic ext_irq_zero_pending;
   logic ext_irq_one_pending;
   sfr_byte_t timer_control_reg;
   logic [2:0] sel_zero;
   logic [2:0] sel_one;

   // ---------------------------------------------
   // pin selection and detectors
   // ---------------------------------------------
   // taps the pad level only, so a crossbar peripheral on the pin is unaffected
   assign sel_zero = cur.ext_irq_pin_config[`PINCFG_SEL_ZERO_LSB +: 3];
   assign sel_one = cur.ext_irq_pin_config[`PINCFG_SEL_ONE_LSB +: 3];
   assign zero_if.pin_level = port_pins[sel_zero];
   assign one_if.pin_level = port_pins[sel_one];
   assign zero_if.polarity = cur.ext_irq_pin_config[`PINCFG_POL_ZERO];
   assign one_if.polarity = cur.ext_irq_pin_config[`PINCFG_POL_ONE];
   assign zero_if.edge_mode = cur.ext_irq_zero_sense;
   assign one_if.edge_mode = cur.ext_irq_one_sense;
   assign zero_if.vector_ack = ext_irq_zero_vector_ack;
   assign one_if.vector_ack = ext_irq_one_vector_ack;
   assign ext_irq_zero_pending = zero_if.pending;
   assign ext_irq_one_pending = one_if.pending;

   ext_irq_detector u_det_zero (
      .clk(clk),
      .srst(srst),
      .cfg(zero_if)
   );

   ext_irq_detector u_det_one (
      .clk(clk),
      .srst(srst),
      .cfg(one_if)
   );

   // ---------------------------------------------
   // register file
   // ---------------------------------------------
   always_comb begin
      timer_control_reg = 8'h00;
      timer_control_reg[`TIMER_CONTROL_REG_SENSE_ZERO] = cur.ext_irq_zero_sense;
      timer_control_reg[`TIMER_CONTROL_REG_PEND_ZERO] = ext_irq_zero_pending;
      timer_control_reg[`TIMER_CONTROL_REG_SENSE_ONE] = cur.ext_irq_one_sense;
      timer_control_reg[`TIMER_CONTROL_REG_PEND_ONE] = ext_irq_one_pending;
   end

   always_comb begin
      next_cur = cur;
      if (sfr_we) begin
         case (sfr_addr)
            `ADDR_EXT_IRQ_EN2: begin
               // no page compare: visible from every page
               next_cur.extended_interrupt_enable_two = sfr_wdata & `EN2_WRITE_MASK;
            end
            `ADDR_TIMER_CONTROL: begin
               next_cur.ext_irq_zero_sense = sfr_wdata[`TIMER_CONTROL_REG_SENSE_ZERO];
               next_cur.ext_irq_one_sense = sfr_wdata[`TIMER_CONTROL_REG_SENSE_ONE];
            end
            `ADDR_EXT_IRQ_PIN_CONFIG: begin
               next_cur.ext_irq_pin_config = sfr_wdata;
            end
            default: begin
               next_cur.ext_irq_pin_config = cur.ext_irq_pin_config;
            end
         endcase
      end
      case (sfr_addr)
         `ADDR_EXT_IRQ_EN2: next_cur.rdata = cur.extended_interrupt_enable_two;
         `ADDR_TIMER_CONTROL: next_cur.rdata = timer_control_reg;
         `ADDR_EXT_IRQ_PIN_CONFIG: next_cur.rdata = cur.ext_irq_pin_config;
         default: next_cur.rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cur <= '{extended_interrupt_enable_two: `EN2_RESET,
            ext_irq_pin_config: `PINCFG_RESET,
            ext_irq_zero_sense: 1'b0,
            ext_irq_one_sense: 1'b0,
            rdata: 8'h00};
      end else begin
         cur <= next_cur;
      end
   end

   assign sfr_rdata = cur.rdata;
   assign sfr_hit = (sfr_addr == `ADDR_EXT_IRQ_EN2) || (sfr_addr == `ADDR_TIMER_CONTROL)
      || (sfr_addr == `ADDR_EXT_IRQ_PIN_CONFIG);

   // ---------------------------------------------
   // request masking
   // ---------------------------------------------
   assign cap_scan_end_req = cap_scan_end_flag
      & cur.extended_interrupt_enable_two[`EN2_CAP_SCAN_END];
   assign cap_compare_req = cap_compare_flag
      & cur.extended_interrupt_enable_two[`EN2_CAP_COMPARE];
   assign cap_conv_done_req = cap_conv_done_flag
      & cur.extended_interrupt_enable_two[`EN2_CAP_CONV];
   assign rtc_alarm_req = rtc_alarm_flag
      & cur.extended_interrupt_enable_two[`EN2_RTC_ALARM];
   assign port_match_req = port_match_flag
      & cur.extended_interrupt_enable_two[`EN2_PORT_MATCH];
   assign supply_warn_req = supply_warn_flag
      & cur.extended_interrupt_enable_two[`EN2_SUPPLY_WARN];
   // level mode relies on the source holding and releasing in time
   assign ext_irq_zero_req = ext_irq_zero_pending;
   assign ext_irq_one_req = ext_irq_one_pending;
endmodule

// >>> core/irq_consts.svh
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// register addresses on the special-function bus
`define ADDR_EXT_IRQ_EN2 8'he7
`define ADDR_TIMER_CONTROL 8'h88
`define ADDR_EXT_IRQ_PIN_CONFIG 8'he4

// extended enable register layout
`define EN2_RESET 8'h00
`define EN2_WRITE_MASK 8'h77
`define EN2_SUPPLY_WARN 0
`define EN2_PORT_MATCH 1
`define EN2_RTC_ALARM 2
`define EN2_CAP_CONV 4
`define EN2_CAP_COMPARE 5
`define EN2_CAP_SCAN_END 6

// timer control register bits owned here
`define TIMER_CONTROL_REG_SENSE_ZERO 0
`define TIMER_CONTROL_REG_PEND_ZERO 1
`define TIMER_CONTROL_REG_SENSE_ONE 2
`define TIMER_CONTROL_REG_PEND_ONE 3

// pin configuration register layout
`define PINCFG_RESET 8'h01
`define PINCFG_SEL_ZERO_LSB 0
`define PINCFG_POL_ZERO 3
`define PINCFG_SEL_ONE_LSB 4
`define PINCFG_POL_ONE 7

`endif

// >>> core/irq_pkg.sv
package irq_pkg;
   typedef logic [7:0] sfr_byte_t;
   typedef enum logic [1:0] {
      SENSE_IDLE = 2'b01,
      SENSE_ACTIVE = 2'b10
   } sense_state_t;
endpackage

// >>> core/ext_irq_cfg_if.sv
`timescale 1ns/1ps
interface ext_irq_cfg_if;
   logic pin_level;
   logic polarity;
   logic edge_mode;
   logic vector_ack;
   logic pending;
   modport ctrl (output pin_level, output polarity, output edge_mode, output vector_ack,
      input pending);
   modport det (input pin_level, input polarity, input edge_mode, input vector_ack,
      output pending);
endinterface

// >>> core/ext_irq_detector.sv
`timescale 1ns/1ps
module ext_irq_detector (
   input wire logic clk,
   input wire logic srst,
   ext_irq_cfg_if.det cfg
);
   import irq_pkg::*;

   typedef struct packed {
      logic sync_a;
      logic sync_b;
      logic edge_flag;
      sense_state_t state;
   } det_state_t;

   det_state_t cur;
   det_state_t next_cur;
   logic active;

   // ---------------------------------------------
   // sampling and detection
   // ---------------------------------------------
   always_comb begin
      next_cur = cur;
      next_cur.sync_a = cfg.pin_level;
      next_cur.sync_b = cur.sync_a;
      active = (cur.sync_b == cfg.polarity);
      case (cur.state)
         SENSE_IDLE: begin
            if (active) begin
               next_cur.state = SENSE_ACTIVE;
               if (cfg.edge_mode) begin
                  next_cur.edge_flag = 1'b1;
               end
            end
         end
         SENSE_ACTIVE: begin
            if (!active) begin
               next_cur.state = SENSE_IDLE;
            end
         end
         default: begin
            next_cur.state = SENSE_IDLE;
         end
      endcase
      // an edge landing on the acknowledge cycle survives
      if (cfg.vector_ack && !(cur.state == SENSE_IDLE && active && cfg.edge_mode)) begin
         next_cur.edge_flag = 1'b0;
      end
      if (!cfg.edge_mode) begin
         next_cur.edge_flag = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cur <= '{sync_a: 1'b0, sync_b: 1'b0, edge_flag: 1'b0, state: SENSE_ACTIVE};
      end else begin
         cur <= next_cur;
      end
   end

   // level mode follows the synchronised pin level, with no latch
   assign cfg.pending = cfg.edge_mode ? cur.edge_flag : active;
endmodule

// >>> bench/irq_enable_and_external_irq_properties.sv
`timescale 1ns/1ps
module irq_checker #(
   parameter int PORT_PINS = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] sfr_addr,
   input wire irq_pkg::sfr_byte_t sfr_wdata,
   input wire logic sfr_we,
   input wire irq_pkg::sfr_byte_t sfr_rdata,
   input wire logic [PORT_PINS-1:0] port_pins,
   input wire logic cap_scan_end_flag,
   input wire logic cap_compare_flag,
   input wire logic cap_conv_done_flag,
   input wire logic rtc_alarm_flag,
   input wire logic port_match_flag,
   input wire logic supply_warn_flag,
   input wire logic ext_irq_zero_vector_ack,
   input wire logic cap_scan_end_req,
   input wire logic cap_compare_req,
   input wire logic cap_conv_done_req,
   input wire logic rtc_alarm_req,
   input wire logic port_match_req,
   input wire logic supply_warn_req,
   input wire logic ext_irq_zero_req
);
   logic [7:0] en;
   logic sense0;
   // shadow of the enable byte and edge-mode bit, rebuilt from bus writes
   always_ff @(posedge clk) begin
      if (srst) begin
         en <= 8'h00;
         sense0 <= 1'b0;
      end else if (sfr_we) begin
         if (sfr_addr == 8'he7) en <= sfr_wdata & 8'h77;
         if (sfr_addr == 8'h88) sense0 <= sfr_wdata[0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // pins quiet long enough that no edge is still in the synchroniser
   sequence s_quiet;
      $stable(port_pins)[*4];
   endsequence
   a_scan_end_mask: assert property (cap_scan_end_req == (cap_scan_end_flag & en[6]))
      else $error("scan end request wrong");
   a_compare_mask: assert property (cap_compare_req == (cap_compare_flag & en[5]))
      else $error("compare request wrong");
   a_conv_done_mask: assert property (cap_conv_done_req == (cap_conv_done_flag & en[4]))
      else $error("conversion request wrong");
   a_rtc_alarm_mask: assert property (rtc_alarm_req == (rtc_alarm_flag & en[2]))
      else $error("alarm request wrong");
   a_port_match_mask: assert property (port_match_req == (port_match_flag & en[1]))
      else $error("port match request wrong");
   a_supply_warn_mask: assert property (supply_warn_req == (supply_warn_flag & en[0]))
      else $error("supply warning request wrong");
   a_enable_readback: assert property (sfr_addr == 8'he7 && !sfr_we |=> sfr_rdata == $past(en))
      else $error("enable readback wrong");
   a_ack_clears_edge: assert property (s_quiet ##0 (sense0 && ext_irq_zero_vector_ack)
      |=> !ext_irq_zero_req) else $error("pending not cleared by vectoring");
endmodule
bind irq_enable_and_external_irq irq_checker #(.PORT_PINS(PORT_PINS)) chk (.*);

// >>> bench/core_vector_model.sv
`timescale 1ns/1ps
module core_vector_model #(
   parameter int LAT = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [1:0] req,
   output logic [1:0] ack
);
   int cnt [2];
   // one vectoring pulse per request stretch, a few cycles late like a busy core
   always_ff @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         ack[i] <= 1'b0;
         if (srst || !req[i]) begin
            cnt[i] <= 0;
         end else begin
            cnt[i] <= cnt[i] + 1;
            ack[i] <= (cnt[i] == LAT);
         end
      end
   end
endmodule

// >>> bench/irq_enable_and_external_irq_tb_top.sv
`timescale 1ns/1ps
module irq_enable_and_external_irq_tb_top;
   import irq_pkg::*;
   logic clk = 0, srst = 1, sfr_we = 0;
   logic [7:0] sfr_addr = 8'h00, pins = 8'hff, v;
   sfr_byte_t sfr_wdata = 8'h00;
   sfr_byte_t sfr_rdata;
   logic [5:0] fl = 6'h00;
   logic [5:0] rq;
   logic [1:0] xr, ack;
   logic hit;
   int num_errors = 0;
   int n_tests = 0;
   irq_enable_and_external_irq dut (.clk(clk), .srst(srst), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_rdata(sfr_rdata), .sfr_hit(hit),
      .port_pins(pins), .cap_scan_end_flag(fl[5]), .cap_compare_flag(fl[4]),
      .cap_conv_done_flag(fl[3]), .rtc_alarm_flag(fl[2]), .port_match_flag(fl[1]),
      .supply_warn_flag(fl[0]), .ext_irq_zero_vector_ack(ack[0]),
      .ext_irq_one_vector_ack(ack[1]), .cap_scan_end_req(rq[5]), .cap_compare_req(rq[4]),
      .cap_conv_done_req(rq[3]), .rtc_alarm_req(rq[2]), .port_match_req(rq[1]),
      .supply_warn_req(rq[0]), .ext_irq_zero_req(xr[0]), .ext_irq_one_req(xr[1]));
   core_vector_model core (.clk(clk), .srst(srst), .req(xr), .ack(ack));
   // ----------------
   // bus, pin and check tasks
   // ----------------
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) begin
         sfr_addr <= a;
         sfr_wdata <= d;
         sfr_we <= 1'b1;
      end
      @(posedge clk) sfr_we <= 1'b0;
      #1;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk) sfr_addr <= a;
      @(posedge clk) #1 d = sfr_rdata;
   endtask
   task pin_step(input logic [7:0] p, input int n);
      @(posedge clk) pins <= p;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      complete_run;
   end
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      rd(8'he7, v); chk("enable reset", 8'h00, v);
      chk("enable hit", 8'h01, {7'h00, hit});
      rd(8'h11, v); chk("unmapped read", 8'h00, v);
      chk("unmapped hit", 8'h00, {7'h00, hit});
      @(posedge clk) fl <= 6'h3f;
      for (int b = 0; b < 8; b++) begin
         wr(8'he7, 8'h01 << b);
         // bits 7 and 3 are unused, so those writes pass no request at all
         v = (b == 3 || b == 7) ? 8'h00 : 8'h01 << (b - (b > 3));
         chk("masked requests", v, {2'b00, rq});
      end
      wr(8'he7, 8'hff);
      rd(8'he7, v); chk("enable readback", 8'h77, v);
      chk("all requests", 8'h3f, {2'b00, rq});
      pin_step(pins, 0);
      @(posedge clk) fl <= 6'h00;
      @(posedge clk) #1 chk("flags off", 8'h00, {2'b00, rq});
      pin_step(8'hfc, 3); chk("level low pending", 8'h03, {6'h00, xr});
      rd(8'h88, v); chk("pending bits", 8'h0a, v & 8'h0f);
      pin_step(8'hfc, 8);
      pin_step(8'hff, 3); chk("level released", 8'h00, {6'h00, xr});
      wr(8'he4, 8'h09);
      pin_step(8'hfe, 3); chk("mixed polarity on", 8'h03, {6'h00, xr});
      pin_step(8'hfd, 3); chk("mixed polarity off", 8'h00, {6'h00, xr});
      wr(8'h88, 8'h01);
      pin_step(8'hff, 3); chk("edge pending", 8'h01, {6'h00, xr});
      pin_step(8'hff, 10); chk("edge cleared", 8'h00, {6'h00, xr});
      complete_run;
   end
endmodule
